// >>> design/opmode_cfg.svh
// Timing counts, widths and limits of the operating-mode sequencer
`ifndef OPMODE_CFG_SVH
`define OPMODE_CFG_SVH

`define CLK_FREQ_HZ        125000000
`define STARTUP_BLINK_MS   3000
`define STARTUP_BLINK_CYC  ((`CLK_FREQ_HZ / 1000) * `STARTUP_BLINK_MS)
`define BLINK_HALF_CYC     25000000
`define NUM_BREAKPOINTS    3
`define MAX_STEP_BPS       2
`define PC_WIDTH           16

`endif

// >>> design/opmode_pkg.sv
// Types shared by the operating-mode sequencer
package opmode_pkg;
    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_STARTUP,
        MODE_RUN,
        MODE_HOLD
    } op_mode_t;
endpackage

// >>> design/bp_if.sv
// Breakpoint match bundle between sequencer and comparator
`timescale 1ns/1ps
`include "opmode_cfg.svh"
interface bp_if;
    logic [`PC_WIDTH-1:0]        pc;
    logic [`NUM_BREAKPOINTS-1:0] bp_valid;
    logic [`PC_WIDTH*`NUM_BREAKPOINTS-1:0] bp_addr;
    logic                        hit;
    logic [1:0]                  num_defined;
    modport seq (output pc, output bp_valid, output bp_addr, input hit, input num_defined);
    modport cmp (input pc, input bp_valid, input bp_addr, output hit, output num_defined);
endinterface

// >>> design/bp_match.sv
// Breakpoint comparator: hit detection and count of defined breakpoints
`timescale 1ns/1ps
`include "opmode_cfg.svh"
module bp_match (
    bp_if.cmp b    // Breakpoint bundle
);
    logic [`NUM_BREAKPOINTS-1:0] eq;
    genvar i;
    generate
        for (i = 0; i < `NUM_BREAKPOINTS; i++) begin : g_cmp
            assign eq[i] = b.bp_valid[i] && (b.bp_addr[i*`PC_WIDTH +: `PC_WIDTH] == b.pc);
        end
    endgenerate
    assign b.hit         = |eq;
    assign b.num_defined = 2'(b.bp_valid[0]) + 2'(b.bp_valid[1]) + 2'(b.bp_valid[2]);
endmodule // bp_match

// >>> design/opmode_ctrl.sv
// Operating-mode sequencer: stop, start-up, run and breakpoint hold
// Function
// - The block is always in exactly one of stop, start-up, run or hold.
// - Entering stop halts execution but leaves timers, counters, flags and images untouched.
// - Stop asserts output inhibit, lights the stop lamp and darkens the run lamp once the start-up blink window has ended.
// - Going from stop to run invokes the start-up routine once with no time supervision.
// - During start-up outputs stay inhibited and the stop lamp is dark.
// - The run lamp blinks for at least 3 s from start-up begin, even if stop follows early.
// - When the start-up routine completes the block enters run.
// - Run executes the main cycle routine repeatedly, alarm sections may be inserted.
// - In run timers and counters are active and the process image refreshes each cycle.
// - Run releases output inhibit, darkens the stop lamp and lights the run lamp once the start-up blink window has ended.
// - Up to 3 breakpoints may be set and cleared by the programming device.
// - Reaching an active breakpoint in run enters hold and exposes the registers.
// - In hold the device honours single-step and resume requests.
// - Hold blinks the run lamp, lights the stop lamp, freezes timers and inhibits outputs.
// - Single stepping is refused when more than 2 breakpoints are defined.
`timescale 1ns/1ps
`include "opmode_cfg.svh"
module opmode_ctrl
    import opmode_pkg::*;
#(
    parameter int unsigned BLINK_HALF = `BLINK_HALF_CYC,   // Lamp half period in clocks
    parameter int unsigned WINDOW_CYC = `STARTUP_BLINK_CYC // Minimum start-up blink, clocks
) (
    input  wire logic                        clk,             // 125 MHz clock
    input  wire logic                        rst_n,           // Sync reset, active low
    input  wire logic                        run_req,         // Request run (level)
    input  wire logic                        stop_req,        // Request stop (level)
    input  wire logic                        startup_done,    // Start-up routine finished
    input  wire logic                        cycle_done,      // Main cycle finished
    input  wire logic                        error_evt,       // Fault during execution
    input  wire logic [`PC_WIDTH-1:0]        exec_pc,         // Current statement address
    input  wire logic                        bp_wr,           // Breakpoint write strobe
    input  wire logic [1:0]                  bp_idx,          // Breakpoint slot
    input  wire logic                        bp_set,          // 1 set, 0 clear
    input  wire logic [`PC_WIDTH-1:0]        bp_addr_in,      // Breakpoint address
    input  wire logic                        bp_clr_all,      // Delete all breakpoints
    input  wire logic                        step_req,        // Execute next statement
    input  wire logic                        resume_req,      // Resume to next breakpoint
    output opmode_pkg::op_mode_t             mode,            // Current mode
    output logic                             output_inhibit,  // Digital outputs disabled
    output logic                             run_indicator,   // Run lamp
    output logic                             stop_indicator,  // Stop lamp
    output logic                             startup_start,   // Start-up routine call pulse
    output logic                             main_cycle_start,// Main cycle call pulse
    output logic                             exec_enable,     // Program may advance
    output logic                             timers_active,   // Program timers running
    output logic                             image_refresh,   // Process image refresh pulse
    output logic                             regs_visible,    // Registers shown to device
    output logic                             step_refused     // Step denied pulse
);
    import opmode_pkg::*;

    // ****************************************
    // Breakpoint storage
    // ****************************************
    bp_if b ();
    bp_match bp_match_i (.b(b));

    logic [`NUM_BREAKPOINTS-1:0]            bpv_q;
    logic [`PC_WIDTH*`NUM_BREAKPOINTS-1:0]  bpa_q;

    // Clear-all wins over a slot write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n || bp_clr_all) begin
            bpv_q <= '0;
        end else if (bp_wr && bp_idx < 2'(`NUM_BREAKPOINTS)) begin
            bpv_q[bp_idx] <= bp_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bpa_q <= '0;
        end else if (bp_wr && bp_set && bp_idx < 2'(`NUM_BREAKPOINTS)) begin
            bpa_q[bp_idx*`PC_WIDTH +: `PC_WIDTH] <= bp_addr_in;
        end
    end

    assign b.pc       = exec_pc;
    assign b.bp_valid = bpv_q;
    assign b.bp_addr  = bpa_q;

    // ****************************************
    // Mode sequencer
    // ****************************************
    op_mode_t mode_q, mode_d;
    logic     step_q, step_d;
    logic     suppress_q, suppress_d;

    wire step_ok   = step_req && (b.num_defined <= 2'(`MAX_STEP_BPS));
    // Suppression stops a second halt at the address just resumed from
    wire bp_stop   = b.hit && !suppress_q;

    always_comb begin
        mode_d     = mode_q;
        step_d     = 1'b0;
        suppress_d = suppress_q && b.hit;
        case (mode_q)
            MODE_STOP: begin
                if (run_req && !stop_req) begin
                    mode_d = MODE_STARTUP;
                end
            end
            MODE_STARTUP: begin
                if (error_evt || stop_req) begin
                    mode_d = MODE_STOP;
                end else if (startup_done) begin
                    mode_d = MODE_RUN;
                end
            end
            MODE_RUN: begin
                if (error_evt || stop_req) begin
                    mode_d = MODE_STOP;
                end else if (step_q && !step_req) begin
                    mode_d     = MODE_HOLD;
                    suppress_d = b.hit;
                end else if (bp_stop) begin
                    mode_d     = MODE_HOLD;
                    suppress_d = 1'b1;
                end
            end
            MODE_HOLD: begin
                if (stop_req) begin
                    mode_d = MODE_STOP;
                end else if (resume_req) begin
                    mode_d = MODE_RUN;
                end else if (step_ok) begin
                    mode_d = MODE_RUN;
                    step_d = 1'b1;
                end
            end
            default: mode_d = MODE_STOP;
        endcase
    end

    // ****************************************
    // Sequencer state
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= MODE_STOP;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Marks the single cycle of run that one step is granted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step_q <= 1'b0;
        end else begin
            step_q <= step_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            suppress_q <= 1'b0;
        end else begin
            suppress_q <= suppress_d;
        end
    end

    // ****************************************
    // Start-up blink window and blink divider
    // ****************************************
    // Minimum window is kept running even if stop arrives early
    logic [31:0] win_q;
    logic [31:0] div_q;
    logic        blink_q;
    wire         startup_entry = (mode_q == MODE_STOP) && (mode_d == MODE_STARTUP);
    wire         div_tick      = (div_q == 32'(BLINK_HALF - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win_q <= '0;
        end else if (startup_entry) begin
            win_q <= 32'(WINDOW_CYC);
        end else if (win_q != '0) begin
            win_q <= win_q - 32'h1;
        end
    end

    // Free-running divider: lamp phase is arbitrary, only the rate matters
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q <= '0;
        end else begin
            div_q <= div_tick ? 32'h0 : div_q + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blink_q <= 1'b0;
        end else begin
            blink_q <= div_tick ? ~blink_q : blink_q;
        end
    end

    // ****************************************
    // Output decode
    // ****************************************
    wire in_run   = (mode_d == MODE_RUN);
    wire in_hold  = (mode_d == MODE_HOLD);
    wire in_stop  = (mode_d == MODE_STOP);
    wire in_start = (mode_d == MODE_STARTUP);
    wire blinking = in_start || in_hold || (win_q > 32'h1) || startup_entry;
    wire run_lamp = blinking ? blink_q : in_run;
    wire cyc_go   = in_run && ((mode_q != MODE_RUN) || cycle_done);
    wire refuse   = (mode_q == MODE_HOLD) && step_req && !step_ok
                    && !resume_req && !stop_req;

    // ****************************************
    // Output registers
    // ****************************************
    // Fed from mode_d so every output moves in the same cycle as mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode <= MODE_STOP;
        end else begin
            mode <= mode_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            output_inhibit <= 1'b1;
        end else begin
            output_inhibit <= !in_run;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_indicator <= 1'b0;
        end else begin
            run_indicator <= run_lamp;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stop_indicator <= 1'b1;
        end else begin
            stop_indicator <= in_stop || in_hold;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            startup_start <= 1'b0;
        end else begin
            startup_start <= startup_entry;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            main_cycle_start <= 1'b0;
        end else begin
            main_cycle_start <= cyc_go;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            exec_enable <= 1'b0;
        end else begin
            exec_enable <= in_run || in_start;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timers_active <= 1'b0;
        end else begin
            timers_active <= in_run;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            image_refresh <= 1'b0;
        end else begin
            image_refresh <= cyc_go;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regs_visible <= 1'b0;
        end else begin
            regs_visible <= in_hold;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step_refused <= 1'b0;
        end else begin
            step_refused <= refuse;
        end
    end
endmodule // opmode_ctrl

// >>> dv/opmode_ctrl_properties.sv
// Port-level checker of the operating-mode sequencer
`timescale 1ns/1ps
module opmode_ctrl_properties
    import opmode_pkg::*;
(
    input wire logic           clk,              // Clock
    input wire logic           rst_n,            // Reset
    input wire logic           stop_req,         // Stop
    input wire logic           startup_done,     // Start-up end
    input wire logic           error_evt,        // Fault
    input wire logic           step_req,         // Step
    input wire logic           resume_req,       // Resume
    input opmode_pkg::op_mode_t mode,            // Mode
    input wire logic           output_inhibit,   // Inhibit
    input wire logic           stop_indicator,   // Stop lamp
    input wire logic           startup_start,    // Start-up call
    input wire logic           main_cycle_start, // Cycle call
    input wire logic           timers_active,    // Timers
    input wire logic           regs_visible,     // Registers shown
    input wire logic           step_refused      // Step denied
);
    import opmode_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_step;
        mode == MODE_HOLD && step_req && !resume_req && !stop_req;
    endsequence
    a_stop_exit: assert property (mode == MODE_STOP |=> mode inside {MODE_STOP, MODE_STARTUP})
        else $error("stop left for a mode other than start-up");
    a_stop_lamps: assert property (mode == MODE_STOP |-> output_inhibit && stop_indicator)
        else $error("stop outputs wrong");
    a_startup_call: assert property (startup_start |-> $past(mode) == MODE_STOP ##1 !startup_start)
        else $error("start-up call not a single pulse from stop");
    a_startup_dark: assert property (mode == MODE_STARTUP |-> output_inhibit && !stop_indicator)
        else $error("start-up outputs wrong");
    a_enter_run: assert property (mode == MODE_STARTUP && startup_done && !stop_req && !error_evt
        |=> mode == MODE_RUN && main_cycle_start) else $error("start-up end did not enter run");
    a_run_outputs: assert property (mode == MODE_RUN |-> !output_inhibit && timers_active)
        else $error("run outputs wrong");
    a_hold_state: assert property (mode == MODE_HOLD |-> stop_indicator && regs_visible
        && output_inhibit && !timers_active) else $error("hold outputs wrong");
    a_error_stop: assert property (mode inside {MODE_RUN, MODE_STARTUP} && error_evt
        |=> mode == MODE_STOP) else $error("fault did not force stop");
    a_step_once: assert property (s_step ##1 mode == MODE_RUN |=> mode == MODE_HOLD)
        else $error("single step ran longer than one cycle");
    a_step_refuse: assert property (step_refused |-> $past(step_req) && mode == MODE_HOLD)
        else $error("refusal without a step request in hold");
endmodule // opmode_ctrl_properties

// >>> dv/prog_dev_model.sv
// Programming-device model: mode requests, breakpoints, step and resume
`timescale 1ns/1ps
module prog_dev_model (
    input wire logic   clk,        // Clock
    output logic       run_req,    // Run
    output logic       stop_req,   // Stop
    output logic       bp_wr,      // Slot write
    output logic [1:0] bp_idx,     // Slot
    output logic       bp_set,     // Set or clear
    output logic [15:0] bp_addr_in, // Address
    output logic       bp_clr_all, // Delete all
    output logic       step_req,   // Step
    output logic       resume_req  // Resume
);
    initial begin
        {run_req, stop_req, bp_wr, bp_idx, bp_set, bp_clr_all, step_req, resume_req} = '0;
        bp_addr_in = 16'hFFFF;
    end
    task automatic level(input logic r, input logic s);
        @(posedge clk);
        #1;
        run_req = r;
        stop_req = s;
    endtask
    // Released address shows its inverse, never a stale match
    task automatic set_bp(input logic [1:0] i, input logic [15:0] a);
        @(posedge clk);
        #1;
        {bp_wr, bp_set, bp_idx, bp_addr_in} = {2'b11, i, a};
        @(posedge clk);
        #1;
        {bp_wr, bp_addr_in} = {1'b0, ~a};
    endtask
    task automatic clr_bp(input logic [1:0] i);
        @(posedge clk);
        #1;
        {bp_wr, bp_set, bp_idx} = {2'b10, i};
        @(posedge clk);
        #1;
        bp_wr = 1'b0;
    endtask
    // 0 step, 1 resume, 2 delete all; one clock each
    task automatic cmd(input logic [1:0] k);
        @(posedge clk);
        #1;
        {bp_clr_all, resume_req, step_req} = 3'b001 << k;
        @(posedge clk);
        #1;
        {bp_clr_all, resume_req, step_req} = 3'b000;
    endtask
endmodule // prog_dev_model

// >>> dv/test_opmode_ctrl.sv
// Self-checking testbench of the operating-mode sequencer
`timescale 1ns/1ps
`include "opmode_cfg.svh"
module test_opmode_ctrl;
    import opmode_pkg::*;
    logic clk, rst_n, startup_done, cycle_done, error_evt, run_req, stop_req, bp_wr, bp_set;
    logic bp_clr_all, step_req, resume_req, output_inhibit, run_indicator, stop_indicator;
    logic startup_start, main_cycle_start, exec_enable, timers_active, image_refresh;
    logic regs_visible, step_refused;
    logic [7:0] seen;
    logic [1:0] bp_idx;
    logic [`PC_WIDTH-1:0] exec_pc, bp_addr_in;
    op_mode_t mode;
    int err_total, n_compared, cycles;
    // Short lamp timings so blinking, the window and the steady lamp fit a short run
    opmode_ctrl #(.BLINK_HALF(4), .WINDOW_CYC(12)) opmode_ctrl_i (.clk(clk), .rst_n(rst_n),
        .run_req(run_req), .stop_req(stop_req),
        .startup_done(startup_done), .cycle_done(cycle_done), .error_evt(error_evt),
        .exec_pc(exec_pc), .bp_wr(bp_wr), .bp_idx(bp_idx), .bp_set(bp_set),
        .bp_addr_in(bp_addr_in), .bp_clr_all(bp_clr_all), .step_req(step_req),
        .resume_req(resume_req), .mode(mode), .output_inhibit(output_inhibit),
        .run_indicator(run_indicator), .stop_indicator(stop_indicator),
        .startup_start(startup_start), .main_cycle_start(main_cycle_start),
        .exec_enable(exec_enable), .timers_active(timers_active),
        .image_refresh(image_refresh), .regs_visible(regs_visible), .step_refused(step_refused));
    prog_dev_model prog_dev_model_i (.clk(clk), .run_req(run_req), .stop_req(stop_req),
        .bp_wr(bp_wr), .bp_idx(bp_idx), .bp_set(bp_set), .bp_addr_in(bp_addr_in),
        .bp_clr_all(bp_clr_all), .step_req(step_req), .resume_req(resume_req));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bit 0 set if the lamp was seen dark, bit 1 if seen lit, over 8 cycles
    task automatic blink_seen(output logic [7:0] s);
        s = 8'h00;
        repeat (8) begin
            s[run_indicator] = 1'b1;
            tick(1);
        end
    endtask
    task automatic chk_mode(input op_mode_t m, input logic inh, input logic stp);
        chk({4'h0, mode, output_inhibit, stop_indicator}, {4'h0, m, inh, stp});
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard, far above the fewer than 100 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            results();
        end
    end
    initial begin
        {rst_n, startup_done, cycle_done, error_evt, exec_pc} = '0;
        {err_total, n_compared, cycles} = '0;
        tick(3);
        rst_n = 1'b1;
        chk_mode(MODE_STOP, 1'b1, 1'b1);
        chk(run_indicator, 8'h00);
        prog_dev_model_i.level(1'b1, 1'b0);
        tick(1);
        chk_mode(MODE_STARTUP, 1'b1, 1'b0);
        chk({startup_start, exec_enable}, 8'h03);
        blink_seen(seen);
        chk(seen, 8'h03);
        chk({mode, startup_start}, {MODE_STARTUP, 1'b0});
        pulse(startup_done);
        chk_mode(MODE_RUN, 1'b0, 1'b0);
        chk({main_cycle_start, image_refresh, timers_active}, 8'h07);
        pulse(cycle_done);
        chk({main_cycle_start, image_refresh}, 8'h03);
        $display("test start-up and run done");
        prog_dev_model_i.set_bp(2'h0, 16'h0040);
        exec_pc = 16'h0040;
        tick(1);
        chk_mode(MODE_HOLD, 1'b1, 1'b1);
        chk({regs_visible, timers_active}, 8'h02);
        blink_seen(seen);
        chk(seen, 8'h03);
        prog_dev_model_i.cmd(2'h0);
        chk_mode(MODE_RUN, 1'b0, 1'b0);
        tick(1);
        chk_mode(MODE_HOLD, 1'b1, 1'b1);
        exec_pc = 16'h0000;
        prog_dev_model_i.cmd(2'h1);
        chk_mode(MODE_RUN, 1'b0, 1'b0);
        chk(run_indicator, 8'h01);
        $display("test breakpoint step and resume done");
        prog_dev_model_i.set_bp(2'h1, 16'h0080);
        prog_dev_model_i.set_bp(2'h2, 16'h00C0);
        exec_pc = 16'h00C0;
        tick(1);
        chk_mode(MODE_HOLD, 1'b1, 1'b1);
        prog_dev_model_i.cmd(2'h0);
        chk({mode, step_refused}, {MODE_HOLD, 1'b1});
        prog_dev_model_i.clr_bp(2'h2);
        prog_dev_model_i.cmd(2'h0);
        chk({mode, step_refused}, {MODE_RUN, 1'b0});
        prog_dev_model_i.cmd(2'h2);
        prog_dev_model_i.cmd(2'h1);
        exec_pc = 16'h0040;
        tick(1);
        chk_mode(MODE_RUN, 1'b0, 1'b0);
        prog_dev_model_i.level(1'b0, 1'b1);
        tick(1);
        chk_mode(MODE_STOP, 1'b1, 1'b1);
        chk({exec_enable, timers_active}, 8'h00);
        $display("test breakpoint limit and stop done");
        prog_dev_model_i.level(1'b1, 1'b0);
        tick(1);
        chk_mode(MODE_STARTUP, 1'b1, 1'b0);
        prog_dev_model_i.level(1'b0, 1'b0);
        pulse(error_evt);
        chk_mode(MODE_STOP, 1'b1, 1'b1);
        blink_seen(seen);
        chk(seen, 8'h03);
        tick(3);
        chk(run_indicator, 8'h00);
        $display("test start-up fault done");
        prog_dev_model_i.level(1'b1, 1'b0);
        tick(1);
        pulse(startup_done);
        chk_mode(MODE_RUN, 1'b0, 1'b0);
        pulse(error_evt);
        chk_mode(MODE_STOP, 1'b1, 1'b1);
        $display("test run fault done");
        results();
    end
endmodule // test_opmode_ctrl
bind opmode_ctrl opmode_ctrl_properties opmode_ctrl_properties_i (.clk(clk), .rst_n(rst_n),
    .stop_req(stop_req), .startup_done(startup_done), .error_evt(error_evt),
    .step_req(step_req), .resume_req(resume_req), .mode(mode), .output_inhibit(output_inhibit),
    .stop_indicator(stop_indicator), .startup_start(startup_start),
    .main_cycle_start(main_cycle_start), .timers_active(timers_active),
    .regs_visible(regs_visible), .step_refused(step_refused));
